/* File: hw/rim_pkg.sv */
// package of constants for the remote i/o signal mapper: register map, function codes,
// default assignments, state and operation encodings, timing
// assumes a single 50 MHz clock domain shared by all users of the package
package rim_pkg;

  // function codes shared by input and output assignment fields
  localparam int FN_NONE    = 0;
  localparam int FN_FWD     = 1;
  localparam int FN_RVS     = 2;
  localparam int FN_HOME    = 3;
  localparam int FN_START   = 4;
  localparam int FN_SEQUENTIAL_START  = 5;
  localparam int FN_JOGP    = 6;
  localparam int FN_JOGN    = 7;
  localparam int FN_MS0     = 8;   // direct selects occupy 8..13
  localparam int FN_FREE    = 14;
  localparam int FN_AWO     = 15;
  localparam int FN_STOP    = 16;
  localparam int FN_ALMRST  = 17;
  localparam int FN_PRESET  = 18;
  localparam int FN_HMI     = 19;
  localparam int FN_R0      = 20;  // general bits occupy 20..35
  localparam int FN_M0      = 36;  // op number select occupies 36..41
  localparam int FN_ALM     = 48;  // status functions, output side only
  localparam int FN_WNG     = 49;
  localparam int FN_READY   = 50;
  localparam int FN_HOMEP   = 51;
  localparam int FN_MOVE    = 52;
  localparam int NUM_MS     = 6;
  localparam int NUM_GEN    = 16;
  localparam int NUM_POS    = 16;
  localparam int FN_SPACE   = 64;

  // register byte offsets
  localparam logic [7:0] ADDR_IN_ASG   = 8'h00;  // four words, four 8-bit fields each
  localparam logic [7:0] ADDR_OUT_ASG  = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_MOVE_LEN = 8'h2c;
  localparam logic [7:0] ADDR_CTRL     = 8'h30;
  localparam logic [7:0] ADDR_IN_WORD  = 8'h34;

  // default assignments, position 0 in the low byte
  localparam logic [31:0] IN_ASG0_RST  = 32'h04262524;
  localparam logic [31:0] IN_ASG1_RST  = 32'h0f001003;
  localparam logic [31:0] IN_ASG2_RST  = 32'h050a0908;
  localparam logic [31:0] IN_ASG3_RST  = 32'h02010706;
  localparam logic [31:0] OUT_ASG0_RST = 32'h04262524;
  localparam logic [31:0] OUT_ASG1_RST = 32'h30313233;
  localparam logic [31:0] OUT_ASG2_RST = 32'h00000000;
  localparam logic [31:0] OUT_ASG3_RST = 32'h00003400;
  localparam logic [31:0] MOVE_LEN_RST = 32'h00000064;

  // interrupt status bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_STOP  = 2;
  localparam int IRQ_W     = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DECEL_TIME_NS = 320;
  localparam logic [31:0] DECEL_CYCLES = 32'(DECEL_TIME_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RUN_POS = 3'b001,
    ST_RUN_NEG = 3'b010,
    ST_OP      = 3'b011,
    ST_DECEL   = 3'b100
  } rim_state_type;

  typedef enum logic [2:0] {
    OPK_NONE   = 3'b000,
    OPK_HOME   = 3'b001,
    OPK_START  = 3'b010,
    OPK_SEQUENTIAL_START = 3'b011,
    OPK_JOGP   = 3'b100,
    OPK_JOGN   = 3'b101,
    OPK_DIRECT = 3'b110,
    OPK_CONT   = 3'b111
  } rim_opk_type;

endpackage : rim_pkg

/* File: hw/rim_pos_decode.sv */
// one input position: turns its assigned function code into one-hot vectors
// assumes codes at or above the function space are treated as unassigned
`timescale 1ns/10ps
module rim_pos_decode
  import rim_pkg::*;
(
  input  wire logic [7:0]          i_code,
  input  wire logic                i_bit,
  output logic      [FN_SPACE-1:0] o_asg,
  output logic      [FN_SPACE-1:0] o_hit
);

  // code 0 means unused and maps to no function
  wire logic code_ok = (i_code < 8'(FN_SPACE)) && (i_code != 8'(FN_NONE));

  assign o_asg = code_ok ? (FN_SPACE'(1) << i_code[5:0]) : '0;
  assign o_hit = i_bit ? o_asg : '0;

endmodule : rim_pos_decode

/* File: hw/rim_remote_io_mapper.sv */
// remote i/o signal mapper: maps network input bits onto motion functions, runs a small
// motion sequencer and builds the network output word; registers over axi4-lite
// assumes the remote input word and detector pins are asynchronous to i_sys_clk
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module rim_remote_io_mapper
  import rim_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output logic             o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output logic             o_axi_wready,
  output logic [1:0]       o_axi_bresp,
  output logic             o_axi_bvalid,
  input  wire logic        i_axi_bready,
  input  wire logic [7:0]  i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output logic             o_axi_arready,
  output logic [31:0]      o_axi_rdata,
  output logic [1:0]       o_axi_rresp,
  output logic             o_axi_rvalid,
  input  wire logic        i_axi_rready,
  input  wire logic [15:0] i_remote_input_bits,
  input  wire logic        i_direct_panel_lock_release,
  input  wire logic        i_fault_detect,
  input  wire logic        i_caution_detect,
  output logic [15:0]      o_remote_output_bits,
  output logic [15:0]      o_general_purpose_bits,
  output logic             o_motor_moving,
  output logic             o_motor_dir_neg,
  output logic             o_excite_en,
  output logic             o_op_start,
  output logic [2:0]       o_op_kind,
  output logic [5:0]       o_op_number,
  output logic             o_preset_pulse,
  output logic             o_panel_lock_release,
  output logic             o_fault_present,
  output logic             o_irq
);

  // two-flop synchronisers for everything arriving from outside the clock domain
  logic [18:0] sync1_q, sync2_q;
  always_ff @(posedge i_sys_clk) begin
    sync1_q <= {i_caution_detect, i_fault_detect, i_direct_panel_lock_release,
                i_remote_input_bits};
    sync2_q <= sync1_q;
  end
  wire logic [15:0] in_word   = sync2_q[15:0];
  wire logic        dir_hmi   = sync2_q[16];
  wire logic        fault_det = sync2_q[17];
  wire logic        caution   = sync2_q[18];

  // register file
  logic [31:0]       in_asg_q [4];
  logic [31:0]       out_asg_q [4];
  logic [31:0]       move_len_q;
  logic [IRQ_W-1:0]  irq_stat_q, irq_mask_q;
  logic              ctrl_dir_hmi_q;  // panel lock release also wired as a direct input

  // per-position decode, one instance per remote input bit
  logic [FN_SPACE-1:0] asg_v [NUM_POS];
  logic [FN_SPACE-1:0] hit_v [NUM_POS];
  for (genvar p = 0; p < NUM_POS; p++) begin : g_pos
    rim_pos_decode u_dec (
      .i_code (in_asg_q[p/4][8*(p%4) +: 8]),
      .i_bit  (in_word[p]),
      .o_asg  (asg_v[p]),
      .o_hit  (hit_v[p])
    );
  end

  // duplicate assignments simply or together
  logic [FN_SPACE-1:0] fn_act, fn_asg;
  always_comb begin
    fn_act = '0;
    fn_asg = '0;
    for (int p = 0; p < NUM_POS; p++) begin
      fn_act = fn_act | hit_v[p];
      fn_asg = fn_asg | asg_v[p];
    end
  end

  wire logic       fwd_act   = fn_act[FN_FWD];
  wire logic       rvs_act   = fn_act[FN_RVS];
  wire logic       awo_act   = fn_act[FN_AWO];
  wire logic       stop_act  = fn_act[FN_STOP];
  wire logic       clr_act   = fn_act[FN_ALMRST];
  wire logic [5:0] ms_act    = fn_act[FN_MS0 +: NUM_MS];
  wire logic [5:0] m_num     = fn_act[FN_M0 +: NUM_MS];
  wire logic [15:0] gen_bits = fn_act[FN_R0 +: NUM_GEN];

  // panel lock release: unassigned counts as on, net and direct both needed when both wired
  wire logic net_hmi_ok  = fn_asg[FN_HMI] ? fn_act[FN_HMI] : 1'b1;
  wire logic dir_hmi_ok  = ctrl_dir_hmi_q ? dir_hmi : 1'b1;
  wire logic panel_rel   = net_hmi_ok & dir_hmi_ok;

  // edge detection so a held start launches once
  logic [5:0] start_prev_q;
  logic       preset_prev_q, stop_prev_q;
  wire logic [5:0] start_lvl = {|ms_act, fn_act[FN_JOGN], fn_act[FN_JOGP],
                                fn_act[FN_SEQUENTIAL_START], fn_act[FN_START], fn_act[FN_HOME]};
  wire logic [5:0] start_rise = start_lvl & ~start_prev_q;

  // motion sequencer
  rim_state_type state_q, state_d;
  logic [31:0]   cnt_q, cnt_d;
  logic          fault_q, dir_neg_q, home_pos_q;
  logic [5:0]    seq_q;
  wire logic kill     = awo_act | fault_q;   // excitation off or alarm drops motion at once
  wire logic can_move = ~kill & ~stop_act;
  wire logic op_launch = (state_q == ST_IDLE) & can_move & ~fwd_act & ~rvs_act & |start_rise;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (can_move && fwd_act) begin
          state_d = ST_RUN_POS;
        end else if (can_move && rvs_act) begin
          state_d = ST_RUN_NEG;
        end else if (op_launch) begin
          state_d = ST_OP;
          cnt_d   = move_len_q;
        end
      end
      ST_RUN_POS, ST_RUN_NEG: begin
        if (kill) begin
          state_d = ST_IDLE;
        end else if (stop_act || (state_q == ST_RUN_POS ? !fwd_act : !rvs_act)) begin
          state_d = ST_DECEL;
          cnt_d   = DECEL_CYCLES;
        end
      end
      ST_OP: begin
        if (kill) begin
          state_d = ST_IDLE;
        end else if (stop_act) begin
          state_d = ST_DECEL;
          cnt_d   = DECEL_CYCLES;
        end else if (cnt_q == '0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 32'h00000001;
        end
      end
      ST_DECEL: begin
        if (kill || cnt_q == '0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 32'h00000001;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // operation selection: start uses the op select bits, direct uses the lowest select hit
  logic [5:0]  launch_num;
  rim_opk_type launch_kind;
  always_comb begin
    launch_num  = '0;
    launch_kind = OPK_NONE;
    if (start_rise[0]) begin
      launch_kind = OPK_HOME;
    end else if (start_rise[1]) begin
      launch_kind = OPK_START;
      launch_num  = m_num;
    end else if (start_rise[2]) begin
      launch_kind = OPK_SEQUENTIAL_START;
      launch_num  = seq_q;
    end else if (start_rise[3]) begin
      launch_kind = OPK_JOGP;
    end else if (start_rise[4]) begin
      launch_kind = OPK_JOGN;
    end else begin
      launch_kind = OPK_DIRECT;
      for (int i = NUM_MS - 1; i >= 0; i--) begin
        if (ms_act[i]) begin
          launch_num = 6'(i);
        end
      end
    end
  end

  wire logic fault_set = fault_det & ~fault_q;
  wire logic op_done   = (state_q != ST_IDLE) & (state_d == ST_IDLE);
  wire logic [IRQ_W-1:0] irq_evt = {stop_act & ~stop_prev_q, op_done, fault_set};

  // sequencer and motion-facing outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_q       <= ST_IDLE;
      cnt_q         <= '0;
      fault_q       <= 1'b0;
      dir_neg_q     <= 1'b0;
      home_pos_q    <= 1'b0;
      seq_q         <= '0;
      start_prev_q  <= '0;
      preset_prev_q <= 1'b0;
      stop_prev_q   <= 1'b0;
      o_op_start    <= 1'b0;
      o_op_kind     <= OPK_NONE;
      o_op_number   <= '0;
      o_preset_pulse <= 1'b0;
    end else begin
      state_q       <= state_d;
      cnt_q         <= cnt_d;
      start_prev_q  <= start_lvl;
      preset_prev_q <= fn_act[FN_PRESET];
      stop_prev_q   <= stop_act;
      fault_q       <= fault_det | (fault_q & ~clr_act); // detection wins over clear
      o_op_start    <= op_launch;
      o_preset_pulse <= fn_act[FN_PRESET] & ~preset_prev_q;
      if (state_q == ST_IDLE && state_d == ST_RUN_POS) begin
        dir_neg_q <= 1'b0;
        o_op_kind <= OPK_CONT;
        home_pos_q <= 1'b0;
      end else if (state_q == ST_IDLE && state_d == ST_RUN_NEG) begin
        dir_neg_q <= 1'b1;
        o_op_kind <= OPK_CONT;
        home_pos_q <= 1'b0;
      end else if (op_launch) begin
        dir_neg_q   <= (launch_kind == OPK_JOGN);
        o_op_kind   <= launch_kind;
        o_op_number <= launch_num;
        home_pos_q  <= 1'b0;
        if (launch_kind == OPK_SEQUENTIAL_START) begin
          seq_q <= seq_q + 6'h01;
        end
      end else if (op_done && o_op_kind == OPK_HOME && state_q == ST_OP) begin
        home_pos_q <= 1'b1;  // a return leaving ST_OP for idle, completed or killed, marks home; a stopped one via ST_DECEL does not
      end
    end
  end

  // output word: each position picks one source, unused positions read zero
  wire logic moving = (state_q != ST_IDLE);
  wire logic ready  = ~moving & ~fault_q & ~awo_act;
  logic [FN_SPACE-1:0] out_src;
  always_comb begin
    out_src            = fn_act;
    out_src[FN_NONE]   = 1'b0;
    out_src[FN_ALM]    = fault_q;
    out_src[FN_WNG]    = caution;
    out_src[FN_READY]  = ready;
    out_src[FN_HOMEP]  = home_pos_q;
    out_src[FN_MOVE]   = moving;
  end
  logic [15:0] out_word;
  for (genvar p = 0; p < NUM_POS; p++) begin : g_out
    wire logic [7:0] sel = out_asg_q[p/4][8*(p%4) +: 8];
    assign out_word[p] = (sel < 8'(FN_SPACE)) ? out_src[sel[5:0]] : 1'b0;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_remote_output_bits   <= '0;
      o_general_purpose_bits <= '0;
      o_motor_moving         <= 1'b0;
      o_motor_dir_neg        <= 1'b0;
      o_excite_en            <= 1'b0;
      o_panel_lock_release   <= 1'b0;
      o_fault_present        <= 1'b0;
      o_irq                  <= 1'b0;
    end else begin
      o_remote_output_bits   <= out_word;
      o_general_purpose_bits <= gen_bits;
      o_motor_moving         <= moving;
      o_motor_dir_neg        <= dir_neg_q;
      o_excite_en            <= ~awo_act;
      o_panel_lock_release   <= panel_rel;
      o_fault_present        <= fault_q;
      o_irq                  <= |(irq_stat_q & irq_mask_q);
    end
  end

  // axi4-lite slave: address and data latched independently, write when both held
  logic       aw_have_q, w_have_q;
  logic [7:0] aw_addr_q, ar_addr;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  assign o_axi_awready = ~aw_have_q & ~o_axi_bvalid;
  assign o_axi_wready  = ~w_have_q & ~o_axi_bvalid;
  assign o_axi_arready = ~o_axi_rvalid;
  assign ar_addr       = i_axi_araddr;
  wire logic do_wr = aw_have_q & w_have_q & ~o_axi_bvalid;
  wire logic do_rd = i_axi_arvalid & o_axi_arready;
  wire logic [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
                             {8{w_strb_q[0]}}};
  wire logic [1:0] wr_idx = aw_addr_q[3:2];
  wire logic wr_in   = do_wr & (aw_addr_q[7:4] == ADDR_IN_ASG[7:4]);
  wire logic wr_out  = do_wr & (aw_addr_q[7:4] == ADDR_OUT_ASG[7:4]);
  wire logic wr_mask = do_wr & (aw_addr_q == ADDR_IRQ_MASK);
  wire logic wr_len  = do_wr & (aw_addr_q == ADDR_MOVE_LEN);
  wire logic wr_ctrl = do_wr & (aw_addr_q == ADDR_CTRL);
  wire logic wr_hit  = wr_in | wr_out | wr_mask | wr_len | wr_ctrl |
                       (do_wr & (aw_addr_q == ADDR_STATUS || aw_addr_q == ADDR_IRQ_STAT ||
                                 aw_addr_q == ADDR_IN_WORD));
  wire logic rd_stat = do_rd & (ar_addr == ADDR_IRQ_STAT);

  // read mux; unmapped reads return zero with an error response
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    if (ar_addr[7:4] == ADDR_IN_ASG[7:4] && ar_addr[1:0] == 2'b00) begin
      rd_val = in_asg_q[ar_addr[3:2]];
    end else if (ar_addr[7:4] == ADDR_OUT_ASG[7:4] && ar_addr[1:0] == 2'b00) begin
      rd_val = out_asg_q[ar_addr[3:2]];
    end else begin
      case (ar_addr)
        ADDR_STATUS:   rd_val = {16'h0000, 6'h00, home_pos_q, ready, caution, fault_q,
                                 panel_rel, ~awo_act, dir_neg_q, state_q};
        ADDR_IRQ_STAT: rd_val = 32'(irq_stat_q);
        ADDR_IRQ_MASK: rd_val = 32'(irq_mask_q);
        ADDR_MOVE_LEN: rd_val = move_len_q;
        ADDR_CTRL:     rd_val = 32'(ctrl_dir_hmi_q);
        ADDR_IN_WORD:  rd_val = {16'h0000, in_word};
        default:       rd_ok  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp  <= RESP_OKAY;
      o_axi_rvalid <= 1'b0;
      o_axi_rresp  <= RESP_OKAY;
      o_axi_rdata  <= '0;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_axi_awaddr;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= i_axi_wdata;
        w_strb_q <= i_axi_wstrb;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
      if (do_wr) begin
        o_axi_bvalid <= 1'b1;
        o_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
      if (do_rd) begin
        o_axi_rvalid <= 1'b1;
        o_axi_rdata  <= rd_val;
        o_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end
  end

  // writable registers; interrupt status clears on read but a new event wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      in_asg_q  <= '{IN_ASG0_RST, IN_ASG1_RST, IN_ASG2_RST, IN_ASG3_RST};
      out_asg_q <= '{OUT_ASG0_RST, OUT_ASG1_RST, OUT_ASG2_RST, OUT_ASG3_RST};
      move_len_q <= MOVE_LEN_RST;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
      ctrl_dir_hmi_q <= 1'b0;
    end else begin
      if (wr_in) in_asg_q[wr_idx] <= (in_asg_q[wr_idx] & ~wmask) | (w_data_q & wmask);
      if (wr_out) out_asg_q[wr_idx] <= (out_asg_q[wr_idx] & ~wmask) | (w_data_q & wmask);
      if (wr_len) move_len_q <= (move_len_q & ~wmask) | (w_data_q & wmask);
      if (wr_mask && w_strb_q[0]) irq_mask_q <= w_data_q[IRQ_W-1:0];
      if (wr_ctrl && w_strb_q[0]) ctrl_dir_hmi_q <= w_data_q[0];
      irq_stat_q <= (rd_stat ? '0 : irq_stat_q) | irq_evt;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  a_run_release_decel: assert property (
    (state_q == ST_RUN_POS && !fwd_act && !kill) |=> state_q == ST_DECEL)
    else $error("run release did not decelerate");
  a_start_edge_launch: assert property (
    (state_q == ST_IDLE && can_move && !fwd_act && !rvs_act && |start_rise)
      |=> state_q == ST_OP ##0 o_op_start)
    else $error("start edge did not launch");
  a_held_no_relaunch: assert property (
    (start_lvl == $past(start_lvl)) |=> !o_op_start)
    else $error("launch without a rising edge");
  a_excite_off_stop: assert property (
    (awo_act && moving) |=> !moving ##0 !o_excite_en)
    else $error("excitation off did not drop motion");
  a_stop_input_act: assert property (
    (stop_act && (state_q == ST_OP) && !kill) |=> state_q == ST_DECEL)
    else $error("stop did not decelerate");
  a_fault_clear_act: assert property (
    (fault_q && clr_act && !fault_det) |=> !fault_q ##1 !o_fault_present)
    else $error("alarm not cleared");
  a_panel_default_on: assert property (
    (!fn_asg[FN_HMI] && !ctrl_dir_hmi_q) |=> o_panel_lock_release)
    else $error("unassigned panel release not on");
  a_panel_both_and: assert property (
    (fn_asg[FN_HMI] && ctrl_dir_hmi_q && !dir_hmi) |=> !o_panel_lock_release)
    else $error("panel release ignored direct input");
  a_op_number_sel: assert property (
    (op_launch && launch_kind == OPK_START) |=> o_op_number == $past(m_num))
    else $error("op number mismatch");
  a_move_output: assert property (
    $rose(moving) |=> o_motor_moving ##0 $past(state_q) != ST_IDLE)
    else $error("moving output late");
  a_alarm_output: assert property (
    fault_set |=> fault_q ##1 o_fault_present)
    else $error("alarm output not raised");

  c_cont_run: cover property (state_q == ST_RUN_POS ##[1:40] state_q == ST_DECEL);
  c_pos_op: cover property (op_launch ##1 state_q == ST_OP ##[1:200] state_q == ST_IDLE);
  c_fault_clear: cover property (fault_q ##[1:20] !fault_q);
  c_irq: cover property ($rose(o_irq));

endmodule : rim_remote_io_mapper

/* File: test/rim_host_model.sv */
// host side model: presents the remote input word to the mapper
// assumes the bench may assign one function twice but never uses brake release
`timescale 1ns/10ps
module rim_host_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_word,
  output logic      [15:0] o_remote_input_bits
);
  // registered so the word moves just after an edge, like a link refresh
  always_ff @(posedge i_clk) begin
    o_remote_input_bits <= i_word;
  end
endmodule : rim_host_model

/* File: test/test_rim_remote_io_mapper.sv */
// bench for the remote i/o mapper: axi4-lite master tasks and scenarios
// assumes the host model and the mapper share one 50 MHz clock
`timescale 1ns/10ps
module test_rim_remote_io_mapper;
  import rim_pkg::*;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, fd = 0, dp = 1;
  logic [7:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rdat, rd_v;
  logic [15:0] w = 0, ri, ro, gp;
  logic [1:0] br, rr, rs;
  logic awr, wrr, bv, arr, rv, mov, dn, ex, st, flt, irq, pl;
  logic [2:0] kd;
  logic [5:0] num;
  int n_errors = 0, tests_run = 0, k;
  always #10 clk = ~clk;
  rim_host_model u_rim_host_model (.i_clk(clk), .i_word(w), .o_remote_input_bits(ri));
  rim_remote_io_mapper u_rim_remote_io_mapper (.i_sys_clk(clk), .i_nrst(nrst),
    .i_axi_awaddr(aw), .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wd),
    .i_axi_wstrb(4'hf), .i_axi_wvalid(wv), .o_axi_wready(wrr), .o_axi_bresp(br),
    .o_axi_bvalid(bv), .i_axi_bready(bry), .i_axi_araddr(ar), .i_axi_arvalid(arv),
    .o_axi_arready(arr), .o_axi_rdata(rdat), .o_axi_rresp(rr), .o_axi_rvalid(rv),
    .i_axi_rready(rry), .i_remote_input_bits(ri), .i_direct_panel_lock_release(dp),
    .i_fault_detect(fd), .i_caution_detect(1'b0), .o_remote_output_bits(ro),
    .o_general_purpose_bits(gp), .o_motor_moving(mov), .o_motor_dir_neg(dn),
    .o_excite_en(ex), .o_op_start(st), .o_op_kind(kd), .o_op_number(num),
    .o_preset_pulse(), .o_panel_lock_release(pl), .o_fault_present(flt), .o_irq(irq));
  task end_of_test;
    $display("errors=%0d compares=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // a used-up bound counts against the run and stops it
  task lim(input int c);
    if (c >= 60) begin
      n_errors++;
      end_of_test;
    end
  endtask : lim
  // pending flags, not the driven signals, steer the loop: those change only after the edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, pb;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    for (k = 0; k < 60 && (pa || pw || pb); k++) begin
      @(posedge clk);
      if (pa && awr) begin
        awv <= 0;
        pa = 1'b0;
      end
      if (pw && wrr) begin
        wv <= 0;
        pw = 1'b0;
      end
      if (pb && bv) begin
        bry <= 0;
        pb = 1'b0;
      end
    end
    lim(k);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pr;
    pr = 1'b1;
    @(posedge clk);
    ar <= a;
    arv <= 1;
    rry <= 1;
    for (k = 0; k < 60 && pr; k++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) begin
        d = rdat;
        r = rr;
        rry <= 0;
        pr = 1'b0;
      end
    end
    lim(k);
  endtask : rd
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // defaults of the assignment word and an unmapped read
  task t_regs;
    rd(ADDR_IN_ASG, rd_v, rs); chk(rd_v, IN_ASG0_RST);
    rd(8'hfc, rd_v, rs); chk(rs, RESP_SLVERR);
    $display("regs done");
  endtask : t_regs
  // general bit on two positions, panel release from network and direct inputs
  task t_map;
    wr(ADDR_IN_ASG + 8'h8, 32'h13141408);
    wr(ADDR_CTRL, 32'h1);
    @(posedge clk) w <= 16'h0400;
    wt(6);
    chk({pl, gp}, 17'h00001);
    @(posedge clk) w <= 16'h0a00;
    wt(6);
    chk({pl, gp}, 17'h10001);
    @(posedge clk) dp <= 0;
    wt(6);
    chk(pl, 1'b0);
    @(posedge clk) dp <= 1;
    w <= 16'h0000;
    wr(ADDR_IN_ASG + 8'h8, IN_ASG2_RST);
    wr(ADDR_CTRL, 32'h0);
    wt(6);
    chk({pl, gp}, 17'h10000);
    $display("map done");
  endtask : t_map
  // op number from select bits, echo outputs, launch on the edge only
  task t_start;
    wr(ADDR_MOVE_LEN, 32'h4);
    @(posedge clk) w <= 16'h0003;
    wt(6); chk(ro[2:0], 3'h3);
    @(posedge clk) w <= 16'h000b;
    for (k = 0; k < 60 && st !== 1'b1; k++) @(negedge clk);
    lim(k); chk({kd, num}, {OPK_START, 6'h03});
    wt(1); chk(mov, 1'b1); chk(ro[3], 1'b1);
    chk(ro[13:8], 6'h20);
    wt(12); chk({mov, st}, 2'b00);
    @(posedge clk) w <= 16'h0000;
    $display("start done");
  endtask : t_start
  // continuous run each way, decelerating stop, excitation off
  task t_run;
    @(posedge clk) w <= 16'h8000;
    wt(6); chk({mov, dn}, 2'b11);
    @(posedge clk) w <= 16'h0000;
    wt(10);
    chk(mov, 1'b1);
    wt(15);
    chk(mov, 1'b0);
    @(posedge clk) w <= 16'h4000;
    wt(6);
    chk({mov, dn}, 2'b10);
    @(posedge clk) w <= 16'h4020;
    wt(25);
    chk(mov, 1'b0);
    @(posedge clk) w <= 16'h0080;
    wt(6); chk(ex, 1'b0);
    @(posedge clk) w <= 16'h0000;
    wt(6); chk(ex, 1'b1);
    $display("run done");
  endtask : t_run
  // latched fault, masked interrupt, clear on read and by fault clear
  task t_fault;
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_IN_ASG + 8'h4, 32'h0f111003);
    @(posedge clk) fd <= 1;
    wt(6);
    chk({flt, irq}, 2'b11);
    @(posedge clk) fd <= 0;
    rd(ADDR_IRQ_STAT, rd_v, rs); chk(rd_v[0], 1'b1);
    wt(3); chk({flt, irq}, 2'b10);
    @(posedge clk) w <= 16'h0040;
    wt(6); chk(flt, 1'b0);
    $display("fault done");
  endtask : t_fault
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    wt(4);
    t_regs;
    t_map;
    t_start;
    t_run;
    t_fault;
    end_of_test;
  end
endmodule : test_rim_remote_io_mapper
